//--- core/canceller_b_ctl.sv
// Second canceller control register with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
module canceller_b_ctl
  import canceller_ctl_pkg::*;
#(
  parameter int DEPTH = COEF_DEPTH,
  parameter int WIDTH = COEF_WIDTH
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // AXI4-Lite write address
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read address
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // AXI4-Lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Control to the canceller datapath
  output logic NOISE_INJECTION_ON,
  output logic BACK_TO_BACK_CONFIG,
  output logic ADAPT_ENABLE,
  output logic BYPASS,
  output logic ATTEN_ENABLE,
  output logic [15:0] RX_GAIN,
  // Adaptation engine coefficient port
  input wire logic COEF_WR_REQ,
  input wire logic [$clog2(DEPTH)-1:0] COEF_WR_ADDR,
  input wire logic [WIDTH-1:0] COEF_WR_DATA,
  input wire logic [$clog2(DEPTH)-1:0] COEF_RD_ADDR,
  output logic [WIDTH-1:0] COEF_RD_DATA,
  // Gains register level for the receive path
  input wire logic [15:0] GAIN_LEVEL,
  // Initialization in progress
  output logic INIT_BUSY
);
  // Address width of the coefficient store
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_CLEAR} init_state_t;
  init_state_t init_state_reg;     // Init sequencer
  logic [AW-1:0] clr_addr_reg;      // Clear sweep address
  logic [7:0] ctl_reg;              // Control register one
  logic aw_got_reg;                 // Write address captured
  logic w_got_reg;                  // Write data captured
  logic [7:0] awaddr_reg;           // Captured write address
  logic [31:0] wdata_reg;           // Captured write data
  logic [3:0] wstrb_reg;            // Captured byte enables
  logic bvalid_reg;                 // Write response pending
  logic [1:0] bresp_reg;            // Write response code
  logic rvalid_reg;                 // Read data pending
  logic [1:0] rresp_reg;            // Read response code
  logic [31:0] rdata_reg;           // Read data
  logic wr_fire;                    // Both halves present
  logic init_start;                 // Init requested this cycle
  logic mem_wr_en; // Store write strobe
  logic [AW-1:0] mem_wr_addr; // Store write word
  logic [WIDTH-1:0] mem_wr_data; // Store write value

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Ready while nothing captured and no response pending.
  // Both readies stay low while a response waits: one write in flight,
  // so a captured half can never be overwritten before it fires.
  assign AWREADY = !aw_got_reg && !bvalid_reg;
  assign WREADY = !w_got_reg && !bvalid_reg;
  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;

  // Capture address and data in either order
  // Each half is kept until the write fires; a master may send them apart
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= AWADDR;
      end else if (wr_fire) begin
        aw_got_reg <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_got_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end else if (wr_fire) begin
        w_got_reg <= 1'b0;
      end
    end
  end

  // Response held until the master takes it
  // The code comes from the captured address, not from the live bus
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      // Unmapped addresses answer with a slave error; a write to the
      // status word is accepted and has no effect
      if (awaddr_reg[7:2] == CANCELLER_B_CONTROL_ONE_OFFS[7:2] ||
          awaddr_reg[7:2] == CANCELLER_STATUS_OFFS[7:2]) begin
        bresp_reg <= RESP_OKAY;
      end else begin
        bresp_reg <= RESP_SLVERR;
      end
    end else if (BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // An init write ignores every other bit of the same word: the
  // register simply returns to its power-up value
  assign init_start = wr_fire && wstrb_reg[0] && wdata_reg[INIT_BIT] &&
                      awaddr_reg[7:2] == CANCELLER_B_CONTROL_ONE_OFFS[7:2];

  // Software writes, reserved bits forced to their fixed values.
  // Bits 1 and 0 are reserved: mask and fixed pattern keep them at
  // one and zero whatever software writes.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      // Power-up value
      ctl_reg <= CANCELLER_B_CONTROL_ONE_RST;
    end else if (init_start) begin
      ctl_reg <= CANCELLER_B_CONTROL_ONE_RST;
    end else if (wr_fire && wstrb_reg[0] &&
                 awaddr_reg[7:2] == CANCELLER_B_CONTROL_ONE_OFFS[7:2]) begin
      ctl_reg <= (wdata_reg[7:0] & CANCELLER_B_CONTROL_ONE_WMASK) |
                 CANCELLER_B_CONTROL_ONE_FIXED;
    end
  end

  // ----------------------------------------------------------------
  // Initialization sweep
  // ----------------------------------------------------------------
  // Walks every coefficient to zero; adaptation is held off meanwhile.
  // The sweep also runs straight out of reset, so the store never holds
  // stale words; it takes one cycle per word.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      init_state_reg <= ST_CLEAR;
      clr_addr_reg <= '0;
    end else begin
      case (init_state_reg)
        ST_IDLE: begin
          // Waits for an init write
          if (init_start) begin
            init_state_reg <= ST_CLEAR;
            clr_addr_reg <= '0;
          end
        end
        ST_CLEAR: begin
          if (clr_addr_reg == AW'(DEPTH - 1)) begin
            // Last word written, adaptation may resume
            init_state_reg <= ST_IDLE;
          end
          // Wraps to zero after the last word
          clr_addr_reg <= clr_addr_reg + AW'(1);
        end
        default: init_state_reg <= ST_IDLE;
      endcase
    end
  end
  assign INIT_BUSY = (init_state_reg == ST_CLEAR);

  // The sweep writes zeros; adaptation writes otherwise. Bypass only
  // stops adaptation here and leaves the stored words as they are, so
  // a return from bypass starts from the old coefficients.
  always_comb begin
    mem_wr_en = 1'b0;
    mem_wr_addr = COEF_WR_ADDR;
    mem_wr_data = COEF_WR_DATA;
    if (init_state_reg == ST_CLEAR) begin
      mem_wr_en = 1'b1;
      mem_wr_addr = clr_addr_reg;
      mem_wr_data = '0;
    end else if (COEF_WR_REQ && ADAPT_ENABLE) begin
      mem_wr_en = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Coefficient store
  // ----------------------------------------------------------------
  // Read data come one cycle after the address
  coef_mem #(
    .DEPTH(DEPTH),
    .WIDTH(WIDTH)
  ) u_coef_mem (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr(COEF_RD_ADDR),
    .rd_data(COEF_RD_DATA)
  );

  // ----------------------------------------------------------------
  // Datapath controls
  // ----------------------------------------------------------------
  // All controls follow the register level, ADAPT_ENABLE also the sweep; nothing here is pulsed
  // comfort noise gate
  assign NOISE_INJECTION_ON = !ctl_reg[NOISE_INJECTION_OFF_BIT];
  assign BACK_TO_BACK_CONFIG = ctl_reg[BACK_TO_BACK_CONFIG_BIT];
  // freeze keeps coefficients, filter still runs
  assign ADAPT_ENABLE = !ctl_reg[ADAPTATION_FREEZE_BIT] &&
                        !ctl_reg[BYPASS_BIT] && !INIT_BUSY;
  // Bypass routes the signals around the filter
  assign BYPASS = ctl_reg[BYPASS_BIT];
  // Fixed attenuation select for the receive path
  assign ATTEN_ENABLE = ctl_reg[ATTEN_BIT];

  // Registered so the receive path sees one clean value per cycle;
  // the gain follows a register change one cycle later
  // fixed attenuation or gains register level
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RX_GAIN <= 16'h0000;
    end else if (ctl_reg[ATTEN_BIT]) begin
      RX_GAIN <= ATTEN_12DB_GAIN;
    end else begin
      RX_GAIN <= GAIN_LEVEL;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // One read in flight: a new address waits until the answer is taken
  assign ARREADY = !rvalid_reg;

  // One-cycle answer, held until taken
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (ARVALID && ARREADY) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      if (ARADDR[7:2] == CANCELLER_B_CONTROL_ONE_OFFS[7:2]) begin
        // Control word in the low byte, upper bits zero
        rdata_reg <= {24'h00_0000, ctl_reg};
      end else if (ARADDR[7:2] == CANCELLER_STATUS_OFFS[7:2]) begin
        // Status word: bit 0 shows the clear sweep
        rdata_reg <= {31'h0000_0000, INIT_BUSY};
      end else begin
        // Unmapped reads answer zero with a slave error
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= RESP_SLVERR;
      end
    end else if (RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign RVALID = rvalid_reg;
  assign RDATA = rdata_reg;
  assign RRESP = rresp_reg;
endmodule // canceller_b_ctl
`default_nettype wire

//--- core/canceller_ctl_pkg.sv
// Constants for the second canceller control register block
package canceller_ctl_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CANCELLER_B_CONTROL_ONE_OFFS = 8'h20;
  localparam logic [7:0] CANCELLER_B_CONTROL_ONE_RST = 8'h02;
  localparam logic [7:0] CANCELLER_B_CONTROL_ONE_WMASK = 8'hFC;
  localparam logic [7:0] CANCELLER_B_CONTROL_ONE_FIXED = 8'h02;
  // Status register offset of the block's own state
  localparam logic [7:0] CANCELLER_STATUS_OFFS = 8'h24;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int INIT_BIT = 7;
  localparam int NOISE_INJECTION_OFF_BIT = 6;
  localparam int BACK_TO_BACK_CONFIG_BIT = 5;
  localparam int ATTEN_BIT = 4;
  localparam int BYPASS_BIT = 3;
  localparam int ADAPTATION_FREEZE_BIT = 2;
  // ----------------------------------------------------------------
  // Coefficient store and bus answers
  // ----------------------------------------------------------------
  localparam int COEF_DEPTH = 16;
  localparam int COEF_WIDTH = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Attenuation gain 12 dB, as Q1.15 value approx 0.2512
  localparam logic [15:0] ATTEN_12DB_GAIN = 16'h2026;
endpackage

//--- core/coef_mem.sv
// Coefficient store of the adaptive filter, cleared by a sweep through its write port
`timescale 1ns/1ps
`default_nettype none
module coef_mem
  import canceller_ctl_pkg::*;
#(
  parameter int DEPTH = COEF_DEPTH,
  parameter int WIDTH = COEF_WIDTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Registered read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];  // Coefficient words

  // Write, no reset so it maps to RAM
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data from a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // coef_mem
`default_nettype wire

//--- tb/canceller_b_ctl_monitor.sv
// Port checker for the second canceller control register block
`timescale 1ns/1ps
`default_nettype none
module canceller_b_ctl_monitor
  import canceller_ctl_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Register bus
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  // Datapath controls
  input wire logic NOISE_INJECTION_ON,
  input wire logic BACK_TO_BACK_CONFIG,
  input wire logic ADAPT_ENABLE,
  input wire logic BYPASS,
  input wire logic ATTEN_ENABLE,
  input wire logic [15:0] RX_GAIN,
  input wire logic [15:0] GAIN_LEVEL,
  input wire logic INIT_BUSY
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Adaptation only runs with no bypass and no sweep
  chk_adapt_gated: assert property (ADAPT_ENABLE
    |-> !BYPASS && !INIT_BUSY)
    else $error("adaptation enabled while bypassed or clearing");
  chk_atten_gain: assert property ($past(RST_N) && $past(ATTEN_ENABLE)
    |-> RX_GAIN == ATTEN_12DB_GAIN) else $error("attenuation gain wrong");
  chk_level_gain: assert property ($past(RST_N) && !$past(ATTEN_ENABLE)
    |-> RX_GAIN == $past(GAIN_LEVEL)) else $error("level gain wrong");
  // Sweep length is fixed by the coefficient depth
  chk_sweep_ends: assert property ($rose(INIT_BUSY)
    |-> ##14 INIT_BUSY ##[1:3] !INIT_BUSY) else $error("sweep length wrong");
  chk_init_starts: assert property (AWVALID && AWREADY && WVALID && WREADY
    && AWADDR[7:2] == CANCELLER_B_CONTROL_ONE_OFFS[7:2]
    && WSTRB[0] && WDATA[INIT_BIT]
    |-> ##[1:3] INIT_BUSY) else $error("init write did not start sweep");
  chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read not answered");
  // Decode looks at word addresses only
  chk_unmapped_read: assert property (ARVALID && ARREADY
    && ARADDR[7:2] != CANCELLER_B_CONTROL_ONE_OFFS[7:2]
    && ARADDR[7:2] != CANCELLER_STATUS_OFFS[7:2]
    |=> RRESP == RESP_SLVERR && RDATA == 32'h0000_0000)
    else $error("unmapped read answer wrong");
  // A taken answer is withdrawn on the next edge
  chk_read_retires: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read answer not retired");
  // Both halves taken together are answered two edges later
  chk_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY
    |-> ##2 BVALID) else $error("write not answered");
  // Control read shows fixed bits and the noise injection and back-to-back controls
  chk_ctl_readback: assert property (ARVALID && ARREADY
    && ARADDR[7:2] == CANCELLER_B_CONTROL_ONE_OFFS[7:2]
    |=> RDATA[31:7] == 25'h000_0000 && RDATA[1:0] == 2'b10
    && RDATA[NOISE_INJECTION_OFF_BIT] == !$past(NOISE_INJECTION_ON)
    && RDATA[BACK_TO_BACK_CONFIG_BIT] == $past(BACK_TO_BACK_CONFIG))
    else $error("control read back wrong");
  cover property ($rose(INIT_BUSY));
  cover property (ATTEN_ENABLE);
  cover property (RVALID && RRESP == RESP_SLVERR);
endmodule // canceller_b_ctl_monitor

bind canceller_b_ctl canceller_b_ctl_monitor i_canceller_b_ctl_monitor (
  .CLK_SYS, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
  .WREADY, .BVALID, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
  .RREADY, .NOISE_INJECTION_ON, .BACK_TO_BACK_CONFIG,
  .ADAPT_ENABLE, .BYPASS, .ATTEN_ENABLE, .RX_GAIN, .GAIN_LEVEL, .INIT_BUSY
);
`default_nettype wire

//--- tb/canceller_b_ctl_tb.sv
// Self-checking bench of the second canceller control register
`timescale 1ns/1ps
`default_nettype none
module canceller_b_ctl_tb;
  import canceller_ctl_pkg::*;
  logic CLK_SYS = 1'b0, RST_N = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0;
  // Ready held high: always legal for the master
  logic BREADY = 1'b1, RREADY = 1'b1, COEF_WR_REQ = 1'b0;
  logic [31:0] WDATA = 32'h0000_0000, RDATA;
  logic [3:0] WSTRB = 4'hF, COEF_WR_ADDR = 4'h0, COEF_RD_ADDR = 4'h0;
  logic [1:0] BRESP, RRESP;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, INIT_BUSY;
  logic NOISE_INJECTION_ON, BACK_TO_BACK_CONFIG, ADAPT_ENABLE, BYPASS;
  logic ATTEN_ENABLE;
  logic [15:0] RX_GAIN, COEF_RD_DATA, COEF_WR_DATA = 16'h0000;
  logic [15:0] GAIN_LEVEL = 16'h1234;
  int n_fail = 0, num_checks = 0, cyc = 0;

  always #5 CLK_SYS = ~CLK_SYS;

  canceller_b_ctl i_canceller_b_ctl (
    .CLK_SYS, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .NOISE_INJECTION_ON, .BACK_TO_BACK_CONFIG,
    .ADAPT_ENABLE, .BYPASS, .ATTEN_ENABLE, .RX_GAIN, .COEF_WR_REQ,
    .COEF_WR_ADDR, .COEF_WR_DATA, .COEF_RD_ADDR, .COEF_RD_DATA, .GAIN_LEVEL,
    .INIT_BUSY
  );

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write: AW and W offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge CLK_SYS);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    chk("bresp", {30'h0, er}, {30'h0, BRESP});
  endtask

  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge CLK_SYS);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    chk("rdata", e, RDATA);
    chk("rresp", {30'h0, er}, {30'h0, RRESP});
  endtask

  // Datapath controls, sampled when settled
  task automatic see(input logic [5:0] e);
    @(negedge CLK_SYS);
    chk("controls", {26'h0, e}, {26'h0, NOISE_INJECTION_ON,
      BACK_TO_BACK_CONFIG, ADAPT_ENABLE, BYPASS, ATTEN_ENABLE, INIT_BUSY});
  endtask

  // Receive path gain, sampled when settled
  task automatic gain_is(input logic [15:0] e);
    @(negedge CLK_SYS);
    chk("gain", {16'h0, e}, {16'h0, RX_GAIN});
  endtask

  // Coefficient write try at word 3, then read back
  task automatic coef(input logic we, input logic [15:0] d, input logic [15:0] e);
    @(posedge CLK_SYS);
    COEF_WR_REQ <= we;
    COEF_WR_ADDR <= 4'h3;
    COEF_WR_DATA <= d;
    COEF_RD_ADDR <= 4'h3;
    @(posedge CLK_SYS);
    COEF_WR_REQ <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    chk("coef", {16'h0, e}, {16'h0, COEF_RD_DATA});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (5) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd(8'h20, 32'h0000_0002, RESP_OKAY);
    rd(8'h24, 32'h0000_0001, RESP_OKAY);
    repeat (20) @(posedge CLK_SYS);
    rd(8'h24, 32'h0000_0000, RESP_OKAY);
    see(6'b101000);
    coef(1'b1, 16'hBEEF, 16'hBEEF);
    // Each control bit alone; reserved bits written wrong read fixed
    // back-to-back config set alone as well
    for (int b = 6; b >= 2; b--) begin
      wr(8'h20, 32'h3 | (32'h1 << b), RESP_OKAY);
      // Receive level moves too, so a stale gain cannot pass
      GAIN_LEVEL <= {12'h123, 4'(b)};
      rd(8'h20, 32'h2 | (32'h1 << b), RESP_OKAY);
      see({b != 6, b == 5, b > 3, b == 3, b == 4, 1'b0});
      gain_is(b == 4 ? ATTEN_12DB_GAIN : GAIN_LEVEL);
    end
    coef(1'b1, 16'h1111, 16'hBEEF);
    // Init with other bits set: all return to power-up values
    wr(8'h20, 32'h0000_00FC, RESP_OKAY);
    rd(8'h20, 32'h0000_0002, RESP_OKAY);
    see(6'b100001);
    repeat (20) @(posedge CLK_SYS);
    coef(1'b0, 16'h0000, 16'h0000);
    see(6'b101000);
    rd(8'h30, 32'h0000_0000, RESP_SLVERR);
    wr(8'h30, 32'h0000_00FF, RESP_SLVERR);
    // Low byte lane off: the write is answered and ignored
    WSTRB <= 4'hE;
    wr(8'h20, 32'h0000_0060, RESP_OKAY);
    WSTRB <= 4'hF;
    rd(8'h20, 32'h0000_0002, RESP_OKAY);
    tally_and_finish();
  end
endmodule // canceller_b_ctl_tb
`default_nettype wire
